// >>> hw/lcdd_pkg.sv
// Contract
// - Pixel bus carries six 6-bit codes per clock, bit 0 least significant.
// - Direction high: right pin is start input, columns fill 1 upward, left pin outputs.
// - Bus codes are captured into the data register each clock while loading; the code captures none on clocks 51 and 52.
// - Chain output goes high on the 50th clock after the accepted start.
// - After 52 clocks from start the block stops accepting bus data by itself.
// - Latch strobe rising edge clears the position counter.
// - Latch strobe rising edge copies the whole data register into the latch bank.
// - Latch strobe falling edge starts driving columns with the newly latched codes.
// - Each column presents one of 64 levels chosen by its 6-bit code.
// - Polarity low: odd columns upper group, even lower; high swaps them.
// - Invert select high inverts each incoming code before storing it.
// - Lane 0 feeds first column of each group of six; 50 clocks fill 300.
package lcdd_pkg;
    localparam int LANES = 6;
    localparam int CODE_W = 6;
    localparam int BUS_W = 36;
    localparam int COLUMNS = 300;
    localparam int GROUPS = 50;
    localparam int CNT_W = 6;
    localparam int CHAIN_CLK = 50;
    localparam int STOP_CLK = 52;
    localparam int LINE_W = COLUMNS * CODE_W;
    localparam logic [CNT_W-1:0] CNT_RST = 6'h00;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOAD = 2'b01,
        ST_DONE = 2'b10
    } lcdd_state_e;

    // Synchronised slow pin levels
    typedef struct packed {
        logic dir;
        logic polarity;
        logic strobe;
    } lcdd_pin_s;

    // Commands from the shift side to the output latch bank
    typedef struct packed {
        logic load;
        logic drive;
        logic polarity;
    } lcdd_latch_cmd_s;

    // Data register slot for a group number, mirrored when loading leftward
    function automatic logic [CNT_W-1:0] lcdd_slot(input logic [CNT_W-1:0] grp, input logic dir);
        lcdd_slot = dir ? grp : CNT_W'(GROUPS - 1) - grp;
    endfunction
endpackage

// >>> hw/lcdd_line_latch.sv
// Output latch bank and column drive stage of the column driver
module lcdd_line_latch import lcdd_pkg::*; (
    input wire logic clock, // Shift clock
    input wire logic rst_b, // Async reset, active low
    input wire lcdd_latch_cmd_s cmd, // Load, drive and polarity
    input wire logic [LINE_W-1:0] line_data, // Whole data register
    output logic [LINE_W-1:0] codes, // Codes applied to columns
    output logic [COLUMNS-1:0] upper_ref, // Column uses upper reference group
    output logic drive // Columns are being driven
);
    logic [LINE_W-1:0] bank;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            bank <= '0;
        end else if (cmd.load) begin
            bank <= line_data;
        end
    end

    // drive on falling strobe; six-bit code per column selects one of 64 levels
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            codes <= '0;
            drive <= 1'b0;
        end else if (cmd.drive) begin
            codes <= bank;
            drive <= 1'b1;
        end
    end

    // alternate groups; bit 0 is the first (odd) column
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            upper_ref <= '0;
        end else if (cmd.drive) begin
            upper_ref <= {(COLUMNS / 2){cmd.polarity, ~cmd.polarity}};
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    property p_latch_copy;
        cmd.load |=> bank == $past(line_data);
    endproperty
    a_latch_copy: assert property (p_latch_copy) else $error("latch bank missed the line");

    property p_drive_new;
        cmd.drive && !cmd.load |=> drive && codes == $past(bank);
    endproperty
    a_drive_new: assert property (p_drive_new) else $error("columns not driven with latched codes");

    property p_hold_codes;
        !cmd.drive |=> codes == $past(codes);
    endproperty
    a_hold_codes: assert property (p_hold_codes) else $error("column codes changed without strobe fall");

    property p_polarity;
        cmd.drive |=> upper_ref[0] == !$past(cmd.polarity) && upper_ref[1] == $past(cmd.polarity);
    endproperty
    a_polarity: assert property (p_polarity) else $error("column polarity groups wrong");

    c_drive: cover property (cmd.load ##[1:200] cmd.drive);
endmodule

// >>> hw/lcdd_column_driver.sv
// Digital data path of a 300-column display source driver
module lcdd_column_driver import lcdd_pkg::*; #(
    parameter int CHAIN_AT = CHAIN_CLK, // Clock that raises the chain output
    parameter int STOP_AT = STOP_CLK // Clock after which bus data is ignored
) (
    input wire logic CLOCK, // Shift clock, 20 MHz
    input wire logic RST_B, // Async reset, active low
    input wire logic [BUS_W-1:0] PIXEL_LANES, // Six lanes of 6-bit codes
    input wire logic DIR_SEL, // High loads column 1 first
    input wire logic RIGHT_CHAIN_PULSE_I, // Right chain pin, input side
    output logic RIGHT_CHAIN_PULSE_O, // Right chain pin, output side
    output logic RIGHT_CHAIN_PULSE_OE, // Right chain pin driven
    input wire logic LEFT_CHAIN_PULSE_I, // Left chain pin, input side
    output logic LEFT_CHAIN_PULSE_O, // Left chain pin, output side
    output logic LEFT_CHAIN_PULSE_OE, // Left chain pin driven
    input wire logic LINE_LATCH_STROBE, // Per-line latch strobe
    input wire logic COLUMN_POLARITY_SEL, // Swaps odd/even reference groups
    input wire logic GRAY_INVERT_SEL, // Inverts codes before storing
    output logic [LINE_W-1:0] COLUMN_OUTPUTS, // Code per column, column 1 lowest
    output logic [COLUMNS-1:0] COLUMN_UPPER_REF, // Column uses upper group
    output logic COLUMN_DRIVE // Columns are driven
);
    lcdd_pin_s pin_meta;
    lcdd_pin_s pin_sync;
    logic strobe_prev;
    logic strobe_rise;
    logic strobe_fall;
    logic start_in;
    lcdd_state_e state;
    lcdd_state_e next_state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic chain_pulse;
    logic wr_en;
    logic [CNT_W-1:0] wr_slot;
    logic [BUS_W-1:0] wr_word;
    logic [BUS_W-1:0] data_reg [GROUPS];
    logic [LINE_W-1:0] line_flat;
    lcdd_latch_cmd_s cmd;

    // Slow pins are asynchronous to the shift clock, so two stages first
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            pin_meta <= '0;
            pin_sync <= '0;
            strobe_prev <= 1'b0;
        end else begin
            pin_meta <= '{dir: DIR_SEL, polarity: COLUMN_POLARITY_SEL, strobe: LINE_LATCH_STROBE};
            pin_sync <= pin_meta;
            strobe_prev <= pin_sync.strobe;
        end
    end

    // Strobe edges arrive two to three clocks after the pin moves
    assign strobe_rise = pin_sync.strobe & ~strobe_prev;
    assign strobe_fall = ~pin_sync.strobe & strobe_prev;

    // start comes from the pin facing the load order
    assign start_in = pin_sync.dir ? RIGHT_CHAIN_PULSE_I : LEFT_CHAIN_PULSE_I;

    // Position sequencer
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        if (strobe_rise) begin
            next_state = ST_IDLE;
            next_cnt = CNT_RST;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (start_in) begin
                        next_state = ST_LOAD;
                        next_cnt = CNT_W'(1);
                    end
                end
                ST_LOAD: begin
                    next_cnt = cnt + CNT_W'(1);
                    if (cnt == CNT_W'(STOP_AT - 1)) begin
                        next_state = ST_DONE;
                    end
                end
                ST_DONE: begin
                    next_state = ST_DONE;
                end
                default: begin
                    next_state = ST_IDLE;
                    next_cnt = CNT_RST;
                end
            endcase
        end
    end

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            state <= ST_IDLE;
            cnt <= CNT_RST;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
        end
    end

    // capture while loading; clocks 51 and 52 have no slot left
    assign wr_en = !strobe_rise && ((state == ST_IDLE && start_in) || (state == ST_LOAD && cnt < CNT_W'(GROUPS)));
    // mirrored slot order when loading leftward
    assign wr_slot = lcdd_slot((state == ST_LOAD) ? cnt : CNT_RST, pin_sync.dir);
    // inverting all lanes inverts every code
    assign wr_word = GRAY_INVERT_SEL ? ~PIXEL_LANES : PIXEL_LANES;

    // lanes stored whole, bit 0 of each lane stays least significant
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            for (int g = 0; g < GROUPS; g++) begin
                data_reg[g] <= '0;
            end
        end else if (wr_en) begin
            data_reg[wr_slot] <= wr_word;
        end
    end

    // lane 0 lands on the lowest column of its group of six
    for (genvar g = 0; g < GROUPS; g++) begin : g_flat
        assign line_flat[g*BUS_W +: BUS_W] = data_reg[g];
    end

    // chain pulse on the 50th clock; one clock wide
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            chain_pulse <= 1'b0;
        end else begin
            chain_pulse <= !strobe_rise && state == ST_LOAD && cnt == CNT_W'(CHAIN_AT - 1);
        end
    end

    assign LEFT_CHAIN_PULSE_OE = pin_sync.dir;
    assign RIGHT_CHAIN_PULSE_OE = ~pin_sync.dir;
    assign LEFT_CHAIN_PULSE_O = chain_pulse & pin_sync.dir;
    assign RIGHT_CHAIN_PULSE_O = chain_pulse & ~pin_sync.dir;

    // load on strobe rise, drive on strobe fall
    assign cmd = '{load: strobe_rise, drive: strobe_fall, polarity: pin_sync.polarity};

    lcdd_line_latch u_latch (
        .clock(CLOCK),
        .rst_b(RST_B),
        .cmd(cmd),
        .line_data(line_flat),
        .codes(COLUMN_OUTPUTS),
        .upper_ref(COLUMN_UPPER_REF),
        .drive(COLUMN_DRIVE)
    );

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_B);

    property p_start;
        state == ST_IDLE && start_in && !strobe_rise |=> state == ST_LOAD && cnt == CNT_W'(1);
    endproperty
    a_start: assert property (p_start) else $error("start not taken as first clock");

    property p_capture;
        wr_en |=> data_reg[$past(wr_slot)] == $past(wr_word);
    endproperty
    a_capture: assert property (p_capture) else $error("bus word not captured");

    property p_invert;
        wr_en && GRAY_INVERT_SEL |-> (wr_word ^ PIXEL_LANES) == '1;
    endproperty
    a_invert: assert property (p_invert) else $error("codes not inverted");

    property p_order;
        state == ST_IDLE && start_in |-> wr_slot == (pin_sync.dir ? CNT_RST : CNT_W'(GROUPS - 1));
    endproperty
    a_order: assert property (p_order) else $error("first group in wrong slot");

    property p_chain;
        state == ST_LOAD && cnt == CNT_W'(CHAIN_AT - 1) && !strobe_rise |=> chain_pulse;
    endproperty
    a_chain: assert property (p_chain) else $error("chain pulse late or missing");

    property p_chain_one;
        chain_pulse |=> !chain_pulse;
    endproperty
    a_chain_one: assert property (p_chain_one) else $error("chain pulse wider than one clock");

    property p_stop;
        state == ST_LOAD && cnt == CNT_W'(STOP_AT - 1) && !strobe_rise |=> state == ST_DONE ##1 !wr_en;
    endproperty
    a_stop: assert property (p_stop) else $error("did not stop after 52 clocks");

    property p_clear;
        strobe_rise |=> state == ST_IDLE && cnt == CNT_RST;
    endproperty
    a_clear: assert property (p_clear) else $error("strobe did not clear position");

    property p_idle_quiet;
        state == ST_IDLE && !start_in |-> !wr_en;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("bus data taken while idle");

    property p_late_refused;
        state != ST_IDLE && cnt >= CNT_W'(GROUPS) |-> !wr_en;
    endproperty
    a_late_refused: assert property (p_late_refused) else $error("bus data taken after the last slot");

    property p_done_hold;
        state == ST_DONE && !strobe_rise |=> state == ST_DONE;
    endproperty
    a_done_hold: assert property (p_done_hold) else $error("left done state without strobe");

    property p_chain_pins;
        chain_pulse |-> LEFT_CHAIN_PULSE_O == pin_sync.dir && RIGHT_CHAIN_PULSE_O == !pin_sync.dir;
    endproperty
    a_chain_pins: assert property (p_chain_pins) else $error("chain pulse on wrong pin");

    c_full_line: cover property (state == ST_LOAD ##1 state == ST_DONE);
    c_chain_left: cover property (chain_pulse && pin_sync.dir);
    c_chain_right: cover property (chain_pulse && !pin_sync.dir);
endmodule

// >>> tb/lcdd_ctrl_model.sv
// Timing controller model driving start, pixel lanes and latch strobe
module lcdd_ctrl_model import lcdd_pkg::*; (
    input wire logic clock, // Shift clock
    input wire logic chain_in, // Chain pin facing the next driver
    output logic start, // Start pulse
    output logic [BUS_W-1:0] lanes, // Pixel bus
    output logic strobe // Line latch strobe
);
    timeunit 1ns;
    timeprecision 1ns;
    int chain_at; // Clock count where the chain pulse stood
    int chain_hits; // Cycles the chain pulse stood high

    // Quiet controller at time zero
    initial begin
        start = 1'b0;
        lanes = '0;
        strobe = 1'b0;
    end

    // Code mixed from group, lane and line salt; six bits wide, so values repeat
    function automatic logic [CODE_W-1:0] lane_code(input int g, input int l, input int salt);
        lane_code = CODE_W'(g * 7 + l * 13 + salt);
    endfunction

    // start with group 0
    // Four stray words follow each line, so a missing stop count shows up
    task automatic send_line(input int salt, input int groups);
        chain_hits = 0;
        chain_at = 0;
        @(negedge clock);
        start = 1'b1;
        for (int g = 0; g < groups + 4; g++) begin
            for (int l = 0; l < LANES; l++) begin
                lanes[l*CODE_W +: CODE_W] = (g < groups) ? lane_code(g, l, salt) : ~lane_code(g, l, 0);
            end
            @(posedge clock);
            @(negedge clock);
            start = 1'b0;
            if (chain_in === 1'b1) begin
                chain_hits++;
                chain_at = g + 1;
            end
        end
        // Bus released: inverse rather than a stale copy
        lanes = ~lanes;
    endtask

    task automatic set_strobe(input logic level, input int clks);
        @(negedge clock);
        strobe = level;
        repeat (clks) @(negedge clock);
    endtask
endmodule

// >>> tb/lcdd_column_driver_tb.sv
// Self-checking bench for the column driver data path
module lcdd_column_driver_tb import lcdd_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock, rst_b, dir_sel, polarity_sel, inv_sel, start, strobe, drive;
    logic right_o, right_oe, left_o, left_oe;
    logic [BUS_W-1:0] lanes;
    logic [LINE_W-1:0] cols, exp_line, old_line;
    logic [COLUMNS-1:0] uref, exp_ref;
    wire logic right_w, left_w, chain_w;
    int fails, tests_run;

    // Wire levels: the pin not driven by the driver carries the controller start
    assign right_w = right_oe ? right_o : start;
    assign left_w = left_oe ? left_o : start;
    assign chain_w = dir_sel ? left_w : right_w;

    // 20 MHz shift clock
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    lcdd_column_driver dut_u (
        .CLOCK(clock), .RST_B(rst_b), .PIXEL_LANES(lanes), .DIR_SEL(dir_sel),
        .RIGHT_CHAIN_PULSE_I(right_w), .RIGHT_CHAIN_PULSE_O(right_o), .RIGHT_CHAIN_PULSE_OE(right_oe),
        .LEFT_CHAIN_PULSE_I(left_w), .LEFT_CHAIN_PULSE_O(left_o), .LEFT_CHAIN_PULSE_OE(left_oe),
        .LINE_LATCH_STROBE(strobe), .COLUMN_POLARITY_SEL(polarity_sel), .GRAY_INVERT_SEL(inv_sel),
        .COLUMN_OUTPUTS(cols), .COLUMN_UPPER_REF(uref), .COLUMN_DRIVE(drive)
    );

    lcdd_ctrl_model ctrl_u (
        .clock(clock), .chain_in(chain_w), .start(start), .lanes(lanes), .strobe(strobe)
    );

    task automatic bad(input string msg);
        fails++;
        $display("wrong value at %0t: %s", $time, msg);
    endtask

    // Single exit of the run
    task automatic results();
        $display("Counts: %0d checks, %0d mismatches", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // One line: load, hold strobe high, release, then judge the columns
    task automatic t_line(input logic dir, input logic inv, input logic polarity, input int salt, input int groups);
        logic [CODE_W-1:0] c;
        int g;
        int exp_hits;
        @(negedge clock);
        dir_sel = dir;
        inv_sel = inv;
        polarity_sel = polarity;
        repeat (4) @(negedge clock);
        tests_run++;
        if (left_oe !== dir || right_oe !== ~dir) bad("chain pin enables");
        old_line = exp_line;
        // A cut line keeps loading the released bus (the inverse of the last stray word)
        // for three more clocks, until the strobe rise clears the position; later slots keep the old line
        for (int k = 0; k < groups + 7 && k < GROUPS; k++) begin
            g = dir ? k : GROUPS - 1 - k;
            for (int l = 0; l < LANES; l++) begin
                c = ctrl_u.lane_code((k < groups + 4) ? k : groups + 3, l, (k < groups) ? salt : 0);
                exp_line[(g*LANES+l)*CODE_W +: CODE_W] = ((k < groups || k >= groups + 4) ? c : ~c) ^ {CODE_W{inv}};
            end
        end
        for (int i = 0; i < COLUMNS; i++) begin
            exp_ref[i] = ((i % 2) == 0) ^ polarity;
        end
        exp_hits = (groups == GROUPS) ? 1 : 0;
        ctrl_u.send_line(salt, groups);
        tests_run++;
        if (ctrl_u.chain_hits != exp_hits || (exp_hits == 1 && ctrl_u.chain_at != CHAIN_CLK)) bad("chain pulse");
        ctrl_u.set_strobe(1'b1, 8);
        tests_run++;
        if (cols !== old_line) bad("columns changed before strobe fall");
        ctrl_u.set_strobe(1'b0, 5);
        tests_run++;
        if (cols !== exp_line) bad("column codes");
        tests_run++;
        if (uref !== exp_ref || drive !== 1'b1) bad("reference groups or drive");
    endtask

    // Full line loading rightward, plain codes, polarity low
    task automatic t_full_right();
        t_line(1'b1, 1'b0, 1'b0, 3, GROUPS);
    endtask

    // Short line cut by the strobe, inverted codes, polarity high
    task automatic t_cut_line();
        t_line(1'b1, 1'b1, 1'b1, 9, 10);
    endtask

    // Full line loading leftward with inverted codes
    task automatic t_full_left_inv();
        t_line(1'b0, 1'b1, 1'b1, 21, GROUPS);
    endtask

    // Full line loading leftward, plain codes, polarity low
    task automatic t_full_left();
        t_line(1'b0, 1'b0, 1'b0, 40, GROUPS);
    endtask

    // Main sequence
    initial begin
        rst_b = 1'b0;
        dir_sel = 1'b1;
        polarity_sel = 1'b0;
        inv_sel = 1'b0;
        fails = 0;
        tests_run = 0;
        exp_line = '0;
        repeat (12) @(negedge clock);
        rst_b = 1'b1;
        t_full_right();
        t_cut_line();
        t_full_left_inv();
        t_full_left();
        results();
    end

    // Hang guard
    initial begin
        #2000000;
        bad("run did not finish");
        results();
    end
endmodule
